// ==== rtl/sim_monitor.sv ====
// Safety input monitor: e-stop, light curtain and safety gate personalities.
// Assumes field channels arrive asynchronously and software configures it over Wishbone.
`timescale 1ns/1ps
`include "sim_defines.svh"

module sim_monitor #(
    parameter int SCAN_CYCLES = `SIM_SCAN_CYCLES,
    parameter int SCANS_PER_STEP = `SIM_SCANS_PER_STEP
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [3:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    input wire logic CH1,
    input wire logic CH2,
    input wire logic TEST_REQ,
    output logic RELEASE,
    output logic FAULT,
    output logic MISMATCH_ERR,
    output logic TEST_ERR,
    output logic TEST_REQUIRED
);

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    logic [2:0] meta_ff;
    logic [2:0] sync_ff;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            meta_ff <= 3'h0;
            sync_ff <= 3'h0;
        end else begin
            meta_ff <= {TEST_REQ, CH2, CH1};
            sync_ff <= meta_ff;
        end
    end

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    logic [`SIM_CTRL_WIDTH-1:0] ctrl_ff;
    logic [`SIM_LIMIT_WIDTH-1:0] limit_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [31:0] status_word;
    logic wr_go;

    // A write lands on the edge where the master sees ack, as classic cycles expect.
    assign wr_go = CYC_I & STB_I & WE_I & ack_ff;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= CYC_I & STB_I & ~ack_ff;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl_ff <= `SIM_CTRL_RESET;
        end else if (wr_go && ADR_I == `SIM_OFS_CTRL) begin
            if (SEL_I[0]) begin
                ctrl_ff[7:0] <= DAT_I[7:0];
            end
            if (SEL_I[1]) begin
                ctrl_ff[`SIM_CTRL_WIDTH-1:8] <= DAT_I[`SIM_CTRL_WIDTH-1:8];
            end
        end
    end

    // limit range
    // Values of DAT_I[15:0] above the 30 s ceiling saturate; bits above 15 are ignored.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            limit_ff <= `SIM_LIMIT_RESET;
        end else if (wr_go && ADR_I == `SIM_OFS_LIMIT && SEL_I[1:0] == 2'h3) begin
            if (DAT_I[15:0] > {4'h0, `SIM_LIMIT_MAX}) begin
                limit_ff <= `SIM_LIMIT_MAX;
            end else begin
                limit_ff <= DAT_I[`SIM_LIMIT_WIDTH-1:0];
            end
        end
    end

    always_comb begin
        case (ADR_I)
            `SIM_OFS_CTRL: nxt_rdata = {{(32 - `SIM_CTRL_WIDTH){1'b0}}, ctrl_ff};
            `SIM_OFS_LIMIT: nxt_rdata = {{(32 - `SIM_LIMIT_WIDTH){1'b0}}, limit_ff};
            `SIM_OFS_STATUS: nxt_rdata = status_word;
            default: nxt_rdata = 32'h0;
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rdata_ff <= 32'h0;
        end else if (CYC_I && STB_I && !ack_ff) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign ACK_O = ack_ff;
    assign DAT_O = rdata_ff;

    // ----------------------------------------------------------------
    // Configuration decode
    // ----------------------------------------------------------------
    sim_pkg::sim_pers_t pers;
    sim_pkg::sim_type_t itype;
    logic ftest_en;
    logic run_cfg;

    assign pers = sim_pkg::sim_pers_t'(ctrl_ff[`SIM_CTRL_PERS_LSB +: 2]);
    assign ftest_en = ctrl_ff[`SIM_CTRL_FTEST_BIT] && pers == sim_pkg::SIM_PERS_GATE;
    assign run_cfg = ctrl_ff[`SIM_CTRL_RUN_BIT];

    // curtain dual only
    // A curtain asked for single channel, or the spare code, falls back to equivalent.
    always_comb begin
        itype = sim_pkg::sim_type_t'(ctrl_ff[`SIM_CTRL_TYPE_LSB +: 2]);
        if (itype == sim_pkg::SIM_TYPE_SPARE) begin
            itype = sim_pkg::SIM_TYPE_DUAL_EQ;
        end else if (pers == sim_pkg::SIM_PERS_CURTAIN && itype == sim_pkg::SIM_TYPE_SINGLE) begin
            itype = sim_pkg::SIM_TYPE_DUAL_EQ;
        end
    end

    // ----------------------------------------------------------------
    // Scan timebase
    // ----------------------------------------------------------------
    logic [31:0] scan_cnt_ff;
    logic scan_tick;

    assign scan_tick = scan_cnt_ff == 32'(SCAN_CYCLES - 1);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            scan_cnt_ff <= 32'h0;
        end else if (scan_tick) begin
            scan_cnt_ff <= 32'h0;
        end else begin
            scan_cnt_ff <= scan_cnt_ff + 32'h1;
        end
    end

    // sample per scan
    // Everything below sees inputs only as latched at the scan edge.
    logic ch1_ff;
    logic ch2_ff;
    logic treq_ff;
    logic treq_prev_ff;
    logic run_ff;
    logic run_prev_ff;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ch1_ff <= 1'b0;
            ch2_ff <= 1'b0;
            treq_ff <= 1'b0;
            treq_prev_ff <= 1'b0;
            run_ff <= 1'b0;
            run_prev_ff <= 1'b0;
        end else if (scan_tick) begin
            ch1_ff <= sync_ff[0];
            ch2_ff <= sync_ff[1];
            treq_ff <= sync_ff[2];
            treq_prev_ff <= treq_ff;
            run_ff <= run_cfg;
            run_prev_ff <= run_ff;
        end
    end

    // ----------------------------------------------------------------
    // Channel evaluation
    // ----------------------------------------------------------------
    logic in_active;
    logic in_inactive;
    logic disagree;
    logic to_run;
    logic to_idle;
    logic treq_rise;

    always_comb begin
        case (itype)
            sim_pkg::SIM_TYPE_SINGLE: begin
                in_active = ch1_ff;
                in_inactive = ~ch1_ff;
                disagree = 1'b0;
            end
            sim_pkg::SIM_TYPE_DUAL_COMP: begin
                in_active = ch1_ff & ~ch2_ff;
                in_inactive = ~ch1_ff & ch2_ff;
                disagree = ch1_ff == ch2_ff;
            end
            default: begin
                in_active = ch1_ff & ch2_ff;
                in_inactive = ~ch1_ff & ~ch2_ff;
                disagree = ch1_ff ^ ch2_ff;
            end
        endcase
    end

    assign to_run = run_ff & ~run_prev_ff;
    assign to_idle = ~run_ff & run_prev_ff;
    assign treq_rise = treq_ff & ~treq_prev_ff;

    // ----------------------------------------------------------------
    // Mismatch supervision
    // ----------------------------------------------------------------
    logic [31:0] mm_cnt_ff;
    logic mm_err_ff;
    logic mm_seen_off_ff;
    logic mm_seen_idle_ff;
    logic [31:0] mm_limit;

    assign mm_limit = 32'(limit_ff) * 32'(SCANS_PER_STEP);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mm_cnt_ff <= 32'h0;
        end else if (scan_tick) begin
            if (!disagree || limit_ff == `SIM_LIMIT_WIDTH'(0) || mm_err_ff) begin
                mm_cnt_ff <= 32'h0;
            end else if (mm_cnt_ff <= mm_limit) begin
                mm_cnt_ff <= mm_cnt_ff + 32'h1;
            end
        end
    end

    // clear by off-on or run-idle-run
    // A fresh overrun in the clearing scan wins over the clear.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mm_err_ff <= 1'b0;
        end else if (scan_tick) begin
            if (disagree && limit_ff != `SIM_LIMIT_WIDTH'(0) && mm_cnt_ff >= mm_limit) begin
                mm_err_ff <= 1'b1;
            end else if (mm_err_ff && mm_seen_off_ff && in_active) begin
                mm_err_ff <= 1'b0;
            end else if (mm_err_ff && mm_seen_idle_ff && to_run) begin
                mm_err_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mm_seen_off_ff <= 1'b0;
            mm_seen_idle_ff <= 1'b0;
        end else if (scan_tick) begin
            if (!mm_err_ff) begin
                mm_seen_off_ff <= 1'b0;
                mm_seen_idle_ff <= 1'b0;
            end else begin
                if (in_inactive) begin
                    mm_seen_off_ff <= 1'b1;
                end
                if (to_idle) begin
                    mm_seen_idle_ff <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Gate function test
    // ----------------------------------------------------------------
    sim_pkg::sim_tst_t tst_ff;
    logic treq_armed_ff;
    logic tst_err_ff;

    // fresh test on start
    // Any error also demands a new test once it is cleared.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            tst_ff <= sim_pkg::SIM_TST_WAIT_OPEN;
        end else if (scan_tick) begin
            if (to_run || mm_err_ff || tst_err_ff || (treq_rise && !treq_armed_ff)) begin
                tst_ff <= sim_pkg::SIM_TST_WAIT_OPEN;
            end else begin
                case (tst_ff)
                    sim_pkg::SIM_TST_WAIT_OPEN: begin
                        if (in_inactive) begin
                            tst_ff <= sim_pkg::SIM_TST_WAIT_CLOSE;
                        end
                    end
                    sim_pkg::SIM_TST_WAIT_CLOSE: begin
                        if (in_active) begin
                            tst_ff <= sim_pkg::SIM_TST_DONE;
                        end
                    end
                    default: tst_ff <= sim_pkg::SIM_TST_DONE;
                endcase
            end
        end
    end

    // second request errors
    // The error holds until the next idle to run transition.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            treq_armed_ff <= 1'b0;
            tst_err_ff <= 1'b0;
        end else if (scan_tick) begin
            if (ftest_en && treq_rise && treq_armed_ff && tst_ff != sim_pkg::SIM_TST_DONE) begin
                tst_err_ff <= 1'b1;
            end else if (to_run) begin
                tst_err_ff <= 1'b0;
            end
            if (!ftest_en || to_run || tst_ff == sim_pkg::SIM_TST_DONE) begin
                treq_armed_ff <= ftest_en & treq_rise & ~to_run;
            end else if (treq_rise) begin
                treq_armed_ff <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    logic rel_ff;
    logic flt_ff;
    logic mm_out_ff;
    logic terr_out_ff;
    logic treq_out_ff;
    logic any_err;
    logic tst_pending;

    assign any_err = mm_err_ff | tst_err_ff;
    assign tst_pending = ftest_en && tst_ff != sim_pkg::SIM_TST_DONE;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rel_ff <= 1'b0;
            flt_ff <= 1'b0;
            mm_out_ff <= 1'b0;
            terr_out_ff <= 1'b0;
            treq_out_ff <= 1'b0;
        end else if (scan_tick) begin
            rel_ff <= in_active & ~any_err & ~tst_pending & run_ff & pers != sim_pkg::SIM_PERS_SPARE;
            flt_ff <= any_err & ctrl_ff[`SIM_CTRL_FLTOUT_BIT];
            mm_out_ff <= mm_err_ff & ctrl_ff[`SIM_CTRL_MMOUT_BIT];
            terr_out_ff <= tst_err_ff & ctrl_ff[`SIM_CTRL_TERROUT_BIT];
            treq_out_ff <= tst_pending & ctrl_ff[`SIM_CTRL_TREQOUT_BIT];
        end
    end

    assign RELEASE = rel_ff;
    assign FAULT = flt_ff;
    assign MISMATCH_ERR = mm_out_ff;
    assign TEST_ERR = terr_out_ff;
    assign TEST_REQUIRED = treq_out_ff;

    always_comb begin
        status_word = 32'h0;
        status_word[`SIM_STAT_REL_BIT] = rel_ff;
        status_word[`SIM_STAT_FLT_BIT] = any_err;
        status_word[`SIM_STAT_MM_BIT] = mm_err_ff;
        status_word[`SIM_STAT_TERR_BIT] = tst_err_ff;
        status_word[`SIM_STAT_TREQ_BIT] = tst_pending;
        status_word[`SIM_STAT_RUN_BIT] = run_ff;
    end

endmodule : sim_monitor

// ==== rtl/sim_defines.svh ====
// Offsets, field positions, reset values and timing counts of the safety input monitor.
// Assumes a 50 MHz clock and a byte-addressed 32-bit classic Wishbone register bus.
`ifndef SIM_DEFINES_SVH
`define SIM_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SIM_OFS_CTRL 4'h0
`define SIM_OFS_LIMIT 4'h4
`define SIM_OFS_STATUS 4'h8

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define SIM_CTRL_PERS_LSB 0
`define SIM_CTRL_TYPE_LSB 2
`define SIM_CTRL_FTEST_BIT 4
`define SIM_CTRL_MMOUT_BIT 5
`define SIM_CTRL_FLTOUT_BIT 6
`define SIM_CTRL_TERROUT_BIT 7
`define SIM_CTRL_TREQOUT_BIT 8
`define SIM_CTRL_RUN_BIT 9
`define SIM_CTRL_WIDTH 10

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define SIM_STAT_REL_BIT 0
`define SIM_STAT_FLT_BIT 1
`define SIM_STAT_MM_BIT 2
`define SIM_STAT_TERR_BIT 3
`define SIM_STAT_TREQ_BIT 4
`define SIM_STAT_RUN_BIT 5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SIM_CTRL_RESET 10'h004
`define SIM_LIMIT_WIDTH 12
`define SIM_LIMIT_RESET 12'h003
`define SIM_LIMIT_MAX 12'hbb8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SIM_CLK_PERIOD_NS 20
`define SIM_SCAN_PERIOD_NS 1000000
`define SIM_LIMIT_STEP_NS 10000000
`define SIM_SCAN_CYCLES (`SIM_SCAN_PERIOD_NS / `SIM_CLK_PERIOD_NS)
`define SIM_SCANS_PER_STEP (`SIM_LIMIT_STEP_NS / `SIM_SCAN_PERIOD_NS)

`endif

// ==== rtl/sim_pkg.sv ====
// Types shared by the safety input monitor.
// Assumes nothing beyond a SystemVerilog compiler.
package sim_pkg;

    typedef enum logic [1:0] {
        SIM_PERS_ESTOP,
        SIM_PERS_CURTAIN,
        SIM_PERS_GATE,
        SIM_PERS_SPARE
    } sim_pers_t;

    typedef enum logic [1:0] {
        SIM_TYPE_SINGLE,
        SIM_TYPE_DUAL_EQ,
        SIM_TYPE_DUAL_COMP,
        SIM_TYPE_SPARE
    } sim_type_t;

    typedef enum {
        SIM_TST_DONE,
        SIM_TST_WAIT_OPEN,
        SIM_TST_WAIT_CLOSE
    } sim_tst_t;

endpackage : sim_pkg

// ==== verification/sim_field.sv ====
// Field-side model: two safety contacts and the machine's test request line.
// Assumes the bench commands each state; the pins move just after a clock edge.
`timescale 1ns/1ps
module sim_field (
    input wire logic clk,
    input wire logic want_ch1,
    input wire logic want_ch2,
    input wire logic want_treq,
    output logic ch1,
    output logic ch2,
    output logic test_req
);
    initial begin
        ch1 = 1'h0;
        ch2 = 1'h0;
        test_req = 1'h0;
    end
    // Contacts move unrelated to the scan, so the monitor must resynchronise them.
    always @(posedge clk) begin
        ch1 <= want_ch1;
        ch2 <= want_ch2;
        test_req <= want_treq;
    end
endmodule : sim_field

// ==== verification/sim_monitor_chk.sv ====
// Concurrent checks on the ports of the safety input monitor.
// Assumes one clock and a scan period of at least four clocks.
`timescale 1ns/1ps
module sim_monitor_chk #(
    parameter int SCAN_CYCLES = 4
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [3:0] ADR_I,
    input wire logic [31:0] DAT_O,
    input wire logic ACK_O,
    input wire logic CH1,
    input wire logic RELEASE,
    input wire logic FAULT,
    input wire logic MISMATCH_ERR,
    input wire logic TEST_ERR
);
    logic [4:0] open_cnt_ff;
    // Sync, sampling and update lag stay well inside four scans.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            open_cnt_ff <= 5'h0;
        end else if (CH1) begin
            open_cnt_ff <= 5'h0;
        end else if (open_cnt_ff != 5'h1f) begin
            open_cnt_ff <= open_cnt_ff + 5'h1;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    sequence bus_req_s;
        CYC_I && STB_I && !ACK_O;
    endsequence
    sequence hold_scan_s;
        $stable(RELEASE) [*3];
    endsequence
    ack_answer_a: assert property (bus_req_s |=> ACK_O) else $error("ack late");
    ack_pulse_a: assert property (ACK_O |=> !ACK_O) else $error("ack too long");
    ack_cause_a: assert property (ACK_O |-> $past(CYC_I && STB_I)) else $error("ack unasked");
    dat_hold_a: assert property ($changed(DAT_O) |-> ACK_O) else $error("data moved");
    unmap_zero_a: assert property (ACK_O && !$past(WE_I) && $past(ADR_I) == 4'hc
        |-> DAT_O == 32'h0) else $error("unmapped read nonzero");
    rel_hold_a: assert property ($changed(RELEASE) |=> hold_scan_s) else $error("scan hold");
    rel_open_a: assert property (int'(open_cnt_ff) >= 4 * SCAN_CYCLES |-> !RELEASE)
        else $error("release with channel open");
    mm_norel_a: assert property (MISMATCH_ERR |-> !RELEASE) else $error("release in error");
    terr_norel_a: assert property (TEST_ERR |-> !RELEASE) else $error("release test err");
    reset_quiet_a: assert property (disable iff (1'b0) RST |-> !RELEASE && !ACK_O && !FAULT)
        else $error("outputs active in reset");
endmodule : sim_monitor_chk
bind sim_monitor sim_monitor_chk #(.SCAN_CYCLES(SCAN_CYCLES)) u_chk (.CLK(CLK), .RST(RST),
    .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .CH1(CH1), .RELEASE(RELEASE), .FAULT(FAULT), .MISMATCH_ERR(MISMATCH_ERR),
    .TEST_ERR(TEST_ERR));

// ==== verification/test_safety_input_monitor.sv ====
// Self-checking bench for the safety input monitor.
// Assumes a four-clock scan and two scans per limit step.
`timescale 1ns/1ps
module test_safety_input_monitor;
    typedef struct packed {
        logic [9:0] ctrl;
        logic c1;
        logic c2;
        logic rel;
    } sim_row_t;
    logic clk = 1'h0;
    logic rst = 1'h0;
    logic cyc = 1'h0, stb = 1'h0, we = 1'h0;
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    logic ack, rel, flt, mm, terr, treq, ch1, ch2, tq;
    logic w1 = 1'h0, w2 = 1'h0, wt = 1'h0;
    int failures = 0, checked = 0, cycles = 0;
    // Limit is zero during the table, so disagreeing rows never latch.
    sim_row_t rows [16] = '{'{10'h3e0, 1'h0, 1'h0, 1'h0}, '{10'h3e0, 1'h1, 1'h0, 1'h1},
        '{10'h3e4, 1'h1, 1'h1, 1'h1}, '{10'h3e4, 1'h1, 1'h0, 1'h0}, '{10'h3e4, 1'h0, 1'h0, 1'h0},
        '{10'h3e8, 1'h1, 1'h0, 1'h1}, '{10'h3e8, 1'h1, 1'h1, 1'h0}, '{10'h3e8, 1'h0, 1'h1, 1'h0},
        '{10'h3e8, 1'h0, 1'h0, 1'h0}, '{10'h3e5, 1'h1, 1'h1, 1'h1}, '{10'h3e5, 1'h0, 1'h1, 1'h0},
        '{10'h3e9, 1'h1, 1'h0, 1'h1}, '{10'h3e1, 1'h1, 1'h0, 1'h0}, '{10'h3e2, 1'h1, 1'h0, 1'h1},
        '{10'h3e3, 1'h1, 1'h1, 1'h0}, '{10'h3e2, 1'h0, 1'h0, 1'h0}};
    always #10 clk = ~clk;
    sim_field field (.clk(clk), .want_ch1(w1), .want_ch2(w2), .want_treq(wt), .ch1(ch1),
        .ch2(ch2), .test_req(tq));
    sim_monitor #(.SCAN_CYCLES(4), .SCANS_PER_STEP(2)) dut (.CLK(clk), .RST(rst), .CYC_I(cyc),
        .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(dat_o),
        .ACK_O(ack), .CH1(ch1), .CH2(ch2), .TEST_REQ(tq), .RELEASE(rel), .FAULT(flt),
        .MISMATCH_ERR(mm), .TEST_ERR(terr), .TEST_REQUIRED(treq));
    task automatic summarize();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize
    task automatic chk_bit(input string name, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk_bit
    task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk_word
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk);
        end while (ack !== 1'h1);
        rdat = dat_o;
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
    endtask : wb
    task automatic settle(input int scans);
        repeat (scans * 4) @(posedge clk);
    endtask : settle
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            failures++;
            summarize();
        end
    end
    initial begin
        // A nonblocking update at time zero gives the asynchronous reset a real rising edge.
        rst <= 1'h1;
        repeat (16) @(posedge clk);
        rst <= 1'h0;
        wb(1'h1, 4'h4, 32'h0);
        foreach (rows[i]) begin
            wb(1'h1, 4'h0, {22'h0, rows[i].ctrl});
            w1 <= rows[i].c1;
            w2 <= rows[i].c2;
            settle(8);
            chk_bit("release", rows[i].rel, rel);
            chk_bit("mismatch", 1'h0, mm);
        end
        $display("test table done");
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        wb(1'h0, 4'h0, 32'h0);
        chk_word("ctrl", 32'h4, rdat);
        wb(1'h0, 4'h4, 32'h0);
        chk_word("limit", 32'h3, rdat);
        wb(1'h0, 4'hc, 32'h0);
        chk_word("unmapped", 32'h0, rdat);
        wb(1'h1, 4'h4, 32'hfff);
        wb(1'h0, 4'h4, 32'h0);
        chk_word("limit_max", 32'hbb8, rdat);
        wb(1'h1, 4'h4, 32'h3);
        $display("test registers done");
        w1 <= 1'h1;
        w2 <= 1'h1;
        wb(1'h1, 4'h0, 32'h3e4);
        settle(4);
        chk_bit("release", 1'h1, rel);
        w2 <= 1'h0;
        settle(4);
        chk_bit("early_mismatch", 1'h0, mm);
        settle(8);
        chk_bit("mismatch", 1'h1, mm);
        chk_bit("fault", 1'h1, flt);
        wb(1'h0, 4'h8, 32'h0);
        chk_word("status", 32'h26, rdat);
        w2 <= 1'h1;
        settle(4);
        chk_bit("mismatch_held", 1'h1, mm);
        {w1, w2} <= 2'h0;
        settle(4);
        {w1, w2} <= 2'h3;
        settle(4);
        chk_bit("mismatch_clear", 1'h0, mm);
        chk_bit("release", 1'h1, rel);
        w2 <= 1'h0;
        settle(12);
        chk_bit("mismatch_again", 1'h1, mm);
        w2 <= 1'h1;
        wb(1'h1, 4'h0, 32'h184);
        settle(4);
        chk_bit("mismatch_hidden", 1'h0, mm);
        chk_bit("fault_hidden", 1'h0, flt);
        wb(1'h1, 4'h0, 32'h3e4);
        settle(4);
        chk_bit("mismatch_mode", 1'h0, mm);
        $display("test mismatch done");
        wb(1'h1, 4'h0, 32'h1f2);
        settle(4);
        wb(1'h1, 4'h0, 32'h3f2);
        settle(4);
        chk_bit("test_needed", 1'h1, treq);
        chk_bit("release", 1'h0, rel);
        w1 <= 1'h0;
        settle(4);
        w1 <= 1'h1;
        settle(4);
        chk_bit("test_needed", 1'h0, treq);
        chk_bit("release", 1'h1, rel);
        wt <= 1'h1;
        settle(4);
        wt <= 1'h0;
        settle(4);
        chk_bit("test_needed", 1'h1, treq);
        wt <= 1'h1;
        settle(4);
        chk_bit("test_error", 1'h1, terr);
        chk_bit("release", 1'h0, rel);
        $display("test gate done");
        summarize();
    end
endmodule : test_safety_input_monitor
